//--- hw/sdram_ctrl_pkg.sv
// constants, command codes and states shared by the sdram page controller
package sdram_ctrl_pkg;
	localparam int          NUM_PAGES      = 4;
	localparam int          PAGE_BITS      = 16;
	localparam int          ADDR_PINS      = 20;
	localparam logic [3:0]  INIT_REFRESHES = 4'h8;
	localparam logic [2:0]  BURST_WORDS    = 3'h4;
	localparam logic [11:0] MODE_CL2       = 12'h022;
	localparam logic [11:0] MODE_CL3       = 12'h032;
	localparam int          PRECHG_PIN     = 10;
	localparam int          COL_BASE_BITS  = 8;
	localparam int          ROW_BASE_BITS  = 11;
	localparam logic [1:0]  WIDTH_8        = 2'h0;
	localparam logic [1:0]  WIDTH_16       = 2'h1;
	localparam logic [1:0]  WIDTH_32       = 2'h2;
	localparam logic [1:0]  ROWS_11        = 2'h0;
	localparam logic [1:0]  ROWS_12        = 2'h1;
	localparam logic [1:0]  ROWS_13        = 2'h3;
	// {row strobe, column strobe, write strobe}, all active low
	localparam logic [2:0]  CMD_NOP        = 3'h7;
	localparam logic [2:0]  CMD_ROW_OPEN   = 3'h3;
	localparam logic [2:0]  CMD_READ       = 3'h5;
	localparam logic [2:0]  CMD_WRITE      = 3'h4;
	localparam logic [2:0]  CMD_MODE_SET   = 3'h0;
	localparam logic [2:0]  CMD_PRECHARGE  = 3'h2;
	localparam logic [2:0]  CMD_REFRESH    = 3'h1;
	typedef enum logic [3:0] {
		ST_RST_WAIT, ST_PRE_ALL, ST_REFRESH, ST_MODE_SET, ST_IDLE,
		ST_LOOKUP, ST_CLOSE, ST_OPEN, ST_COLUMN, ST_BURST, ST_DONE
	} state_t;
endpackage : sdram_ctrl_pkg

//--- hw/sdram_page_init_addr_ctrl.sv
// sdram initialisation, open-page tracking and address shifting controller
//
// Overview of operation
// R1 - init trigger starts init when sdram present
// R2 - init: precharge all, eight refreshes, mode set
// R3 - precharge all after reset, delayed by hold
// R4 - software avoids init during an sdram access
// R5 - requester waits for first completed init
// R6 - per space open page stored and compared
// R7 - finished access leaves its row open
// R8 - up to four open pages, any spaces
// R9 - page registers hold sixteen address bits
// R10 - byte select bits follow data bus width
// R11 - least recently used replacement beyond four banks
// R12 - page miss closes bank then opens row
// R13 - pin shift depends on column size only
// R14 - bank bits taken above row field
// R15 - same bank bits on row and column
// R16 - strobes valid only with chip select low
// R17 - data masks: read latency two, write none
// R18 - sdram clock runs at interface clock rate
// R19 - clock enable drops during self refresh
// R20 - four word bursts
// R21 - 32, 16 and 8 bit data buses
// R22 - precharge all encoding with precharge line high
// R23 - mode value 0x0032 or 0x0022
// R24 - any precharge all invalidates every page
`timescale 1ns/1ps
`default_nettype none
module sdram_page_init_addr_ctrl (
	input  wire logic        CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        LINK_CLK_IN,
	input  wire logic        INIT_WRITE_IN,
	input  wire logic [3:0]  SPACE_IS_SDRAM_IN,
	input  wire logic [1:0]  COLUMN_SIZE_IN,
	input  wire logic [1:0]  ROW_SIZE_IN,
	input  wire logic        BANK_SIZE_IN,
	input  wire logic [1:0]  BUS_WIDTH_IN,
	input  wire logic        CAS_LAT3_IN,
	input  wire logic        SELF_REFRESH_IN,
	input  wire logic        HOLD_REQ_N_IN,
	input  wire logic        REQ_VALID_IN,
	input  wire logic        REQ_WRITE_IN,
	input  wire logic [1:0]  REQ_SPACE_IN,
	input  wire logic [23:0] REQ_ADDR_IN,
	input  wire logic [3:0]  REQ_BE_IN,
	input  wire logic [31:0] REQ_WDATA_IN,
	input  wire logic [31:0] DQ_IN,
	output logic             REQ_READY_OUT,
	output logic             DONE_OUT,
	output logic [31:0]      RDATA_OUT,
	output logic             INIT_DONE_OUT,
	output logic             SDRAM_CLK_OUT,
	output logic             CLK_ENABLE_OUT,
	output logic [3:0]       CS_N_OUT,
	output logic             ROW_STROBE_N_OUT,
	output logic             COLUMN_STROBE_N_OUT,
	output logic             WRITE_STROBE_N_OUT,
	output logic [19:0]      ADDR_OUT,
	output logic [3:0]       BYTE_ENABLE_N_OUT,
	output logic [31:0]      DQ_OUT,
	output logic [3:0]       DQ_OE_N_OUT
);

	// request side, CLK_IN domain
	logic        req_tgl_q, init_tgl_q, busy_q;
	logic [1:0]  ack_sync_q, idone_sync_q;
	logic        ack_seen_q;
	logic        wr_hold_q;
	logic [1:0]  sp_hold_q;
	logic [23:0] addr_hold_q;
	logic [3:0]  be_hold_q;
	logic [31:0] wdata_hold_q;
	logic [31:0] rdata_link_q;

	// held request words stay still until the acknowledge returns, so the
	// link side may sample them once it has seen the request toggle
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			req_tgl_q    <= 1'b0;
			busy_q       <= 1'b0;
			wr_hold_q    <= 1'b0;
			sp_hold_q    <= 2'h0;
			addr_hold_q  <= 24'h000000;
			be_hold_q    <= 4'h0;
			wdata_hold_q <= 32'h00000000;
		end else if (REQ_VALID_IN && !busy_q) begin
			req_tgl_q    <= ~req_tgl_q;
			busy_q       <= 1'b1;
			wr_hold_q    <= REQ_WRITE_IN;
			sp_hold_q    <= REQ_SPACE_IN;
			addr_hold_q  <= REQ_ADDR_IN;
			be_hold_q    <= REQ_BE_IN;
			wdata_hold_q <= REQ_WDATA_IN;
		end else if (ack_sync_q[1] != ack_seen_q) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			init_tgl_q <= 1'b0;
		end else if (INIT_WRITE_IN) begin
			init_tgl_q <= ~init_tgl_q; // R1
		end
	end

	logic ack_tgl_q, init_done_q;

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ack_sync_q    <= 2'h0;
			idone_sync_q  <= 2'h0;
			ack_seen_q    <= 1'b0;
			DONE_OUT      <= 1'b0;
			RDATA_OUT     <= 32'h00000000;
			REQ_READY_OUT <= 1'b0;
			INIT_DONE_OUT <= 1'b0;
		end else begin
			ack_sync_q    <= {ack_sync_q[0], ack_tgl_q};
			idone_sync_q  <= {idone_sync_q[0], init_done_q};
			ack_seen_q    <= ack_sync_q[1];
			DONE_OUT      <= ack_sync_q[1] != ack_seen_q;
			if (ack_sync_q[1] != ack_seen_q) begin
				RDATA_OUT <= rdata_link_q;
			end
			REQ_READY_OUT <= !busy_q && !(REQ_VALID_IN && !busy_q);
			INIT_DONE_OUT <= idone_sync_q[1]; // R5
		end
	end

	// link side, LINK_CLK_IN domain
	// configuration is quasi-static; each bit is synchronised on its own
	localparam int CFG_W = 14;
	logic [CFG_W-1:0] cfg_s1_q, cfg_s2_q;
	logic [1:0]       req_sync_q, init_sync_q;
	logic             req_seen_q, init_seen_q;

	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cfg_s1_q    <= '0;
			cfg_s2_q    <= '0;
			req_sync_q  <= 2'h0;
			init_sync_q <= 2'h0;
		end else begin
			cfg_s1_q    <= {SPACE_IS_SDRAM_IN, COLUMN_SIZE_IN, ROW_SIZE_IN, BANK_SIZE_IN,
				BUS_WIDTH_IN, CAS_LAT3_IN, SELF_REFRESH_IN, HOLD_REQ_N_IN};
			cfg_s2_q    <= cfg_s1_q;
			req_sync_q  <= {req_sync_q[0], req_tgl_q};
			init_sync_q <= {init_sync_q[0], init_tgl_q};
		end
	end

	logic [3:0] sdram_sp;
	logic [1:0] col_sz, row_sz, bus_w;
	logic       bank_sz, cas3, self_ref, hold_n;
	assign {sdram_sp, col_sz, row_sz, bank_sz, bus_w, cas3, self_ref, hold_n} = cfg_s2_q;

	// address shift of the held request
	logic [23:0] word_a;
	logic [4:0]  ncb, nrb;
	logic [15:0] page_a;
	logic [1:0]  bank_a;
	logic [19:0] ras_pins, cas_pins, col_mask;

	always_comb begin
		unique case (bus_w)
			sdram_ctrl_pkg::WIDTH_32: word_a = addr_hold_q >> 2; // R10 R21
			sdram_ctrl_pkg::WIDTH_16: word_a = addr_hold_q >> 1; // R10 R21
			default:  word_a = addr_hold_q;      // R10 R21
		endcase
		ncb = 5'(sdram_ctrl_pkg::COL_BASE_BITS) + {3'h0, col_sz}; // R13
		unique case (row_sz)
			sdram_ctrl_pkg::ROWS_12: nrb = 5'(sdram_ctrl_pkg::ROW_BASE_BITS + 1);
			sdram_ctrl_pkg::ROWS_13: nrb = 5'(sdram_ctrl_pkg::ROW_BASE_BITS + 2);
			default:                 nrb = 5'(sdram_ctrl_pkg::ROW_BASE_BITS);
		endcase
		page_a   = 16'(word_a >> ncb); // R9
		bank_a   = 2'(page_a >> nrb) & (bank_sz ? 2'h3 : 2'h1); // R14
		col_mask = 20'((24'h000001 << ncb) - 24'h000001);
		ras_pins = {4'h0, page_a};
		// keep the bank and upper bits on the column phase too
		cas_pins = (ras_pins & ~(20'((24'h000001 << nrb) - 24'h000001))) // R15
			| (20'(word_a) & col_mask);
		cas_pins[sdram_ctrl_pkg::PRECHG_PIN] = 1'b0;
	end

	// page registers with lru ages, 3 = oldest
	logic [3:0]  pg_valid_q;
	logic [1:0]  pg_space_q [4];
	logic [1:0]  pg_bank_q  [4];
	logic [15:0] pg_addr_q  [4];
	logic [1:0]  pg_age_q   [4];
	logic [1:0]  sel_idx, sel_idx_q;
	logic        sel_bank_hit, sel_page_hit, sel_hit_q, sel_close_q;

	always_comb begin
		sel_idx      = 2'h0;
		sel_bank_hit = 1'b0;
		sel_page_hit = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (pg_age_q[i] == 2'h3) sel_idx = 2'(i); // R11
		end
		for (int i = 3; i >= 0; i--) begin
			if (!pg_valid_q[i]) sel_idx = 2'(i);
		end
		for (int i = 0; i < sdram_ctrl_pkg::NUM_PAGES; i++) begin
			if (pg_valid_q[i] && pg_space_q[i] == sp_hold_q && pg_bank_q[i] == bank_a) begin
				sel_idx      = 2'(i); // R6
				sel_bank_hit = 1'b1;
				sel_page_hit = pg_addr_q[i] == page_a; // R6
			end
		end
	end

	sdram_ctrl_pkg::state_t state_q;
	logic [3:0]  cnt_q;
	logic [2:0]  cmd_q;
	logic [3:0]  cs_n_q;
	logic [19:0] addr_q;
	logic [3:0]  dqm_n_q;
	logic [31:0] dq_q;
	logic [3:0]  dq_oe_n_q;
	logic        cke_q;
	logic [3:0]  rd_lat;
	logic        wr_req;
	assign rd_lat = cas3 ? 4'h3 : 4'h2;

	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_q     <= sdram_ctrl_pkg::ST_RST_WAIT;
			cnt_q       <= 4'h0;
			req_seen_q  <= 1'b0;
			init_seen_q <= 1'b0;
			init_done_q <= 1'b0;
			ack_tgl_q   <= 1'b0;
			sel_idx_q   <= 2'h0;
			sel_hit_q   <= 1'b0;
			sel_close_q <= 1'b0;
		end else begin
			unique case (state_q)
				sdram_ctrl_pkg::ST_RST_WAIT: begin
					init_seen_q <= init_sync_q[1];
					if (hold_n) state_q <= sdram_ctrl_pkg::ST_PRE_ALL; // R3
				end
				sdram_ctrl_pkg::ST_PRE_ALL: begin
					cnt_q   <= 4'h0;
					state_q <= (init_sync_q[1] != init_seen_q)
						? sdram_ctrl_pkg::ST_REFRESH : sdram_ctrl_pkg::ST_IDLE;
					init_seen_q <= init_sync_q[1];
				end
				sdram_ctrl_pkg::ST_REFRESH: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == sdram_ctrl_pkg::INIT_REFRESHES - 4'h1) begin
						state_q <= sdram_ctrl_pkg::ST_MODE_SET; // R2
					end
				end
				sdram_ctrl_pkg::ST_MODE_SET: begin
					init_done_q <= 1'b1;
					state_q     <= sdram_ctrl_pkg::ST_IDLE;
				end
				sdram_ctrl_pkg::ST_IDLE: begin
					if (init_sync_q[1] != init_seen_q && sdram_sp != 4'h0) begin
						state_q <= sdram_ctrl_pkg::ST_PRE_ALL; // R1 R4
					end else if (init_sync_q[1] != init_seen_q) begin
						init_seen_q <= init_sync_q[1];
					end else if (req_sync_q[1] != req_seen_q) begin
						req_seen_q <= req_sync_q[1];
						state_q    <= sdram_ctrl_pkg::ST_LOOKUP;
					end
				end
				sdram_ctrl_pkg::ST_LOOKUP: begin
					sel_idx_q   <= sel_idx;
					sel_hit_q   <= sel_page_hit;
					sel_close_q <= sel_bank_hit || pg_valid_q[sel_idx];
					if (sel_page_hit) begin
						state_q <= sdram_ctrl_pkg::ST_COLUMN; // R7
					end else if (sel_bank_hit || pg_valid_q[sel_idx]) begin
						state_q <= sdram_ctrl_pkg::ST_CLOSE; // R12
					end else begin
						state_q <= sdram_ctrl_pkg::ST_OPEN;
					end
				end
				sdram_ctrl_pkg::ST_CLOSE: state_q <= sdram_ctrl_pkg::ST_OPEN; // R12
				sdram_ctrl_pkg::ST_OPEN:  state_q <= sdram_ctrl_pkg::ST_COLUMN;
				sdram_ctrl_pkg::ST_COLUMN: begin
					cnt_q   <= 4'h1;
					state_q <= sdram_ctrl_pkg::ST_BURST;
				end
				sdram_ctrl_pkg::ST_BURST: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == (wr_req ? 4'(sdram_ctrl_pkg::BURST_WORDS) - 4'h1
						: rd_lat + 4'(sdram_ctrl_pkg::BURST_WORDS) - 4'h1)) begin
						state_q <= sdram_ctrl_pkg::ST_DONE; // R20
					end
				end
				sdram_ctrl_pkg::ST_DONE: begin
					ack_tgl_q <= ~ack_tgl_q;
					state_q   <= sdram_ctrl_pkg::ST_IDLE;
				end
				default: state_q <= sdram_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	assign wr_req = wr_hold_q;

	// page table upkeep; a precharge of all banks forgets every page
	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pg_valid_q <= 4'h0;
			for (int i = 0; i < sdram_ctrl_pkg::NUM_PAGES; i++) begin
				pg_space_q[i] <= 2'h0;
				pg_bank_q[i]  <= 2'h0;
				pg_addr_q[i]  <= 16'h0000;
				pg_age_q[i]   <= 2'(i);
			end
		end else if (state_q == sdram_ctrl_pkg::ST_PRE_ALL) begin
			pg_valid_q <= 4'h0; // R24
		end else if (state_q == sdram_ctrl_pkg::ST_OPEN) begin
			pg_valid_q[sel_idx_q] <= 1'b1; // R8
			pg_space_q[sel_idx_q] <= sp_hold_q;
			pg_bank_q[sel_idx_q]  <= bank_a;
			pg_addr_q[sel_idx_q]  <= page_a; // R9
		end else if (state_q == sdram_ctrl_pkg::ST_COLUMN) begin
			for (int i = 0; i < sdram_ctrl_pkg::NUM_PAGES; i++) begin
				if (2'(i) == sel_idx_q) pg_age_q[i] <= 2'h0; // R11
				else if (pg_age_q[i] < pg_age_q[sel_idx_q]) pg_age_q[i] <= pg_age_q[i] + 2'h1;
			end
		end
	end

	// sdram pins, all registered on the link clock
	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cmd_q     <= sdram_ctrl_pkg::CMD_NOP;
			cs_n_q    <= 4'hF;
			addr_q    <= 20'h00000;
			dq_q      <= 32'h00000000;
			dq_oe_n_q <= 4'hF;
			cke_q     <= 1'b1;
		end else begin
			cke_q     <= !self_ref; // R19
			cmd_q     <= sdram_ctrl_pkg::CMD_NOP;
			cs_n_q    <= 4'hF; // R16
			dq_oe_n_q <= 4'hF;
			unique case (state_q)
				sdram_ctrl_pkg::ST_PRE_ALL: begin
					cmd_q  <= sdram_ctrl_pkg::CMD_PRECHARGE; // R22
					cs_n_q <= ~sdram_sp; // R2
					addr_q[sdram_ctrl_pkg::PRECHG_PIN] <= 1'b1; // R22
				end
				sdram_ctrl_pkg::ST_REFRESH: begin
					cmd_q  <= sdram_ctrl_pkg::CMD_REFRESH; // R2
					cs_n_q <= ~sdram_sp;
				end
				sdram_ctrl_pkg::ST_MODE_SET: begin
					cmd_q  <= sdram_ctrl_pkg::CMD_MODE_SET; // R2
					cs_n_q <= ~sdram_sp;
					addr_q <= {8'h00, cas3 ? sdram_ctrl_pkg::MODE_CL3
						: sdram_ctrl_pkg::MODE_CL2}; // R23
				end
				sdram_ctrl_pkg::ST_CLOSE: begin
					cmd_q  <= sdram_ctrl_pkg::CMD_PRECHARGE; // R12
					cs_n_q <= ~(4'h1 << pg_space_q[sel_idx_q]);
					addr_q <= 20'(pg_addr_q[sel_idx_q]);
					addr_q[sdram_ctrl_pkg::PRECHG_PIN] <= 1'b0; // R12
				end
				sdram_ctrl_pkg::ST_OPEN: begin
					cmd_q  <= sdram_ctrl_pkg::CMD_ROW_OPEN;
					cs_n_q <= ~(4'h1 << sp_hold_q);
					addr_q <= ras_pins; // R14
				end
				sdram_ctrl_pkg::ST_COLUMN: begin
					cmd_q  <= wr_req ? sdram_ctrl_pkg::CMD_WRITE : sdram_ctrl_pkg::CMD_READ;
					cs_n_q <= ~(4'h1 << sp_hold_q);
					addr_q <= cas_pins; // R13 R15
					dq_q   <= wdata_hold_q;
					if (wr_req) dq_oe_n_q <= 4'h0;
				end
				sdram_ctrl_pkg::ST_BURST: begin
					// the burst always runs four words; words after the first are masked
					if (wr_req && cnt_q < 4'(sdram_ctrl_pkg::BURST_WORDS)) dq_oe_n_q <= 4'h0;
				end
				default: begin
				end
			endcase
		end
	end

	// data masks: write masks act at once, read masks two cycles ahead of data
	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			dqm_n_q <= 4'hF;
		end else if (state_q == sdram_ctrl_pkg::ST_COLUMN) begin
			dqm_n_q <= ~be_hold_q; // R17
		end else if (state_q == sdram_ctrl_pkg::ST_BURST && !wr_req && cnt_q + 4'h1 < rd_lat) begin
			dqm_n_q <= ~be_hold_q; // R17
		end else begin
			dqm_n_q <= 4'hF; // R17
		end
	end

	// command issued at cnt 1, first read word returns rd_lat edges later
	always_ff @(posedge LINK_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_link_q <= 32'h00000000;
		end else if (state_q == sdram_ctrl_pkg::ST_BURST && !wr_req && cnt_q == rd_lat + 4'h1) begin
			rdata_link_q <= DQ_IN;
		end
	end

	// the forwarded clock is the link clock itself, so it runs at its rate
	assign SDRAM_CLK_OUT       = LINK_CLK_IN; // R18
	assign CLK_ENABLE_OUT      = cke_q;
	assign CS_N_OUT            = cs_n_q;
	assign ROW_STROBE_N_OUT    = cmd_q[2];
	assign COLUMN_STROBE_N_OUT = cmd_q[1];
	assign WRITE_STROBE_N_OUT  = cmd_q[0];
	assign ADDR_OUT            = addr_q;
	assign BYTE_ENABLE_N_OUT   = dqm_n_q;
	assign DQ_OUT              = dq_q;
	assign DQ_OE_N_OUT         = dq_oe_n_q;

endmodule : sdram_page_init_addr_ctrl
`default_nettype wire

//--- test/sdram_ctrl_properties.sv
// port checker for the sdram page controller, with its bind
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_checker (
	input wire logic        CLK_IN,
	input wire logic        NRST_IN,
	input wire logic        LINK_CLK_IN,
	input wire logic [3:0]  SPACE_IS_SDRAM_IN,
	input wire logic [1:0]  ROW_SIZE_IN,
	input wire logic        BANK_SIZE_IN,
	input wire logic        CAS_LAT3_IN,
	input wire logic        SELF_REFRESH_IN,
	input wire logic        SDRAM_CLK_OUT,
	input wire logic        CLK_ENABLE_OUT,
	input wire logic [3:0]  CS_N_OUT,
	input wire logic        ROW_STROBE_N_OUT,
	input wire logic        COLUMN_STROBE_N_OUT,
	input wire logic        WRITE_STROBE_N_OUT,
	input wire logic [19:0] ADDR_OUT
);
	logic [2:0]  cmd;
	logic        sel, every, pre, rfr, mset, opn, col;
	logic [19:0] bnk;
	always_comb begin
		cmd = {ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, WRITE_STROBE_N_OUT};
		sel = CS_N_OUT != 4'hF;
		every = CS_N_OUT == ~SPACE_IS_SDRAM_IN;
		pre = sel && cmd == sdram_ctrl_pkg::CMD_PRECHARGE;
		rfr = every && cmd == sdram_ctrl_pkg::CMD_REFRESH;
		mset = every && cmd == sdram_ctrl_pkg::CMD_MODE_SET;
		opn = sel && cmd == sdram_ctrl_pkg::CMD_ROW_OPEN;
		col = sel && (cmd == sdram_ctrl_pkg::CMD_READ || cmd == sdram_ctrl_pkg::CMD_WRITE);
		// bank bits sit just above the row field, one or two of them
		bnk = (ADDR_OUT >> (ROW_SIZE_IN == 2'h0 ? 11 : ROW_SIZE_IN == 2'h1 ? 12 : 13))
			& {18'h0, BANK_SIZE_IN, 1'b1};
	end
	pre_all_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		pre && ADDR_OUT[10] |-> every) else $error("precharge all missed a space");
	init_seq_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		pre && ADDR_OUT[10] ##1 rfr |=> rfr[*7] ##1 mset) else $error("init order broken");
	mode_val_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		mset |-> ADDR_OUT[11:0] == (CAS_LAT3_IN ? sdram_ctrl_pkg::MODE_CL3
		: sdram_ctrl_pkg::MODE_CL2)) else $error("wrong mode value");
	close_open_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		pre && !ADDR_OUT[10] |=> opn) else $error("no row open after bank close");
	bank_keep_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		opn |=> col && !ADDR_OUT[10] && bnk == $past(bnk)) else $error("bank bits changed");
	cmd_select_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		cmd != sdram_ctrl_pkg::CMD_NOP |-> sel) else $error("command without chip select");
	cke_follow_a: assert property (@(posedge LINK_CLK_IN) disable iff (!NRST_IN)
		$rose(SELF_REFRESH_IN) |-> ##[1:5] !CLK_ENABLE_OUT) else $error("clock enable stuck");
	clk_fwd_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		SDRAM_CLK_OUT == LINK_CLK_IN) else $error("sdram clock not forwarded");
endmodule : sdram_ctrl_checker
bind sdram_page_init_addr_ctrl sdram_ctrl_checker chk (.CLK_IN, .NRST_IN, .LINK_CLK_IN,
	.SPACE_IS_SDRAM_IN, .ROW_SIZE_IN, .BANK_SIZE_IN, .CAS_LAT3_IN, .SELF_REFRESH_IN,
	.SDRAM_CLK_OUT, .CLK_ENABLE_OUT, .CS_N_OUT, .ROW_STROBE_N_OUT, .COLUMN_STROBE_N_OUT,
	.WRITE_STROBE_N_OUT, .ADDR_OUT);
`default_nettype wire

//--- test/sdram_partner.sv
// behavioural sdram devices on the chip-enable spaces
`timescale 1ns/1ps
`default_nettype none
module sdram_partner (
	input  wire logic        clk_in,
	input  wire logic        lat3_in,
	input  wire logic [3:0]  cs_n_in,
	input  wire logic [2:0]  cmd_in,
	input  wire logic [19:0] addr_in,
	input  wire logic [3:0]  dqm_in,
	input  wire logic [3:0]  oe_n_in,
	input  wire logic [31:0] dq_in,
	output logic      [31:0] dq_out
);
	logic [31:0] mem [logic [23:0]];
	logic [31:0] word;
	logic [23:0] key;
	int          cnt = 0;
	initial dq_out = 32'h0;
	always @(posedge clk_in) begin
		key = {cs_n_in, addr_in};
		if (cnt > 0)
			cnt--;
		if (cs_n_in != 4'hF && cmd_in == sdram_ctrl_pkg::CMD_WRITE) begin
			word = mem.exists(key) ? mem[key] : 32'h0;
			for (int b = 0; b < 4; b++)
				if (!dqm_in[b] && !oe_n_in[b])
					word[8*b +: 8] = dq_in[8*b +: 8];
			mem[key] = word;
		end
		if (cs_n_in != 4'hF && cmd_in == sdram_ctrl_pkg::CMD_READ) begin
			word = mem.exists(key) ? mem[key] : {8'h5A, key};
			cnt = lat3_in ? 4 : 3;
		end
		// outside its data window the bus inverts every cycle, so the old word returns on alternate cycles
		dq_out <= (cnt == 1 || cnt == 2) ? word : ~dq_out;
	end
endmodule : sdram_partner
`default_nettype wire

//--- test/sdram_page_init_addr_ctrl_bench.sv
// self-checking bench for the sdram page controller
`timescale 1ns/1ps
`default_nettype none
module sdram_page_init_addr_ctrl_bench;
	localparam logic [31:0] D1 = 32'hA5C30F1E;
	localparam logic [31:0] D2 = 32'h5A3CF0E1;
	logic        CLK_IN = 0, LINK_CLK_IN = 0, NRST_IN = 0, INIT_WRITE_IN = 0;
	logic        CAS_LAT3_IN = 0, SELF_REFRESH_IN = 0, HOLD_REQ_N_IN = 0;
	logic        REQ_VALID_IN = 0, REQ_WRITE_IN = 0;
	logic [1:0]  REQ_SPACE_IN = 0;
	logic [23:0] REQ_ADDR_IN = 0, a0;
	logic [3:0]  REQ_BE_IN = 0, CS_N_OUT, BYTE_ENABLE_N_OUT, DQ_OE_N_OUT;
	logic [31:0] REQ_WDATA_IN = 0, DQ_IN, RDATA_OUT, DQ_OUT, rd;
	logic        REQ_READY_OUT, DONE_OUT, INIT_DONE_OUT, SDRAM_CLK_OUT, CLK_ENABLE_OUT;
	logic        ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, WRITE_STROBE_N_OUT;
	logic [19:0] ADDR_OUT, row_seen, col_seen;
	int          err_total = 0, num_checks = 0, cyc = 0, c;
	int          opens = 0, closes = 0, pres = 0, rfrs = 0, modes = 0;
	always #12.5 CLK_IN = ~CLK_IN;
	always #3 LINK_CLK_IN = ~LINK_CLK_IN;
	sdram_page_init_addr_ctrl uut (.CLK_IN, .NRST_IN, .LINK_CLK_IN, .INIT_WRITE_IN,
		.SPACE_IS_SDRAM_IN(4'h5), .COLUMN_SIZE_IN(2'h0), .ROW_SIZE_IN(2'h0),
		.BANK_SIZE_IN(1'b1), .BUS_WIDTH_IN(2'h2), .CAS_LAT3_IN, .SELF_REFRESH_IN,
		.HOLD_REQ_N_IN, .REQ_VALID_IN, .REQ_WRITE_IN, .REQ_SPACE_IN, .REQ_ADDR_IN,
		.REQ_BE_IN, .REQ_WDATA_IN, .DQ_IN, .REQ_READY_OUT, .DONE_OUT, .RDATA_OUT,
		.INIT_DONE_OUT, .SDRAM_CLK_OUT, .CLK_ENABLE_OUT, .CS_N_OUT, .ROW_STROBE_N_OUT,
		.COLUMN_STROBE_N_OUT, .WRITE_STROBE_N_OUT, .ADDR_OUT, .BYTE_ENABLE_N_OUT,
		.DQ_OUT, .DQ_OE_N_OUT);
	sdram_partner mdl (.clk_in(LINK_CLK_IN), .lat3_in(CAS_LAT3_IN), .cs_n_in(CS_N_OUT),
		.cmd_in({ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, WRITE_STROBE_N_OUT}),
		.addr_in(ADDR_OUT), .dqm_in(BYTE_ENABLE_N_OUT), .oe_n_in(DQ_OE_N_OUT),
		.dq_in(DQ_OUT), .dq_out(DQ_IN));
	// pins are looked at mid-cycle, where the link flops have long settled
	always @(negedge LINK_CLK_IN) if (CS_N_OUT != 4'hF) begin
		case ({ROW_STROBE_N_OUT, COLUMN_STROBE_N_OUT, WRITE_STROBE_N_OUT})
			sdram_ctrl_pkg::CMD_ROW_OPEN: begin opens++; row_seen = ADDR_OUT; end
			sdram_ctrl_pkg::CMD_READ, sdram_ctrl_pkg::CMD_WRITE: col_seen = ADDR_OUT;
			sdram_ctrl_pkg::CMD_PRECHARGE: if (ADDR_OUT[10]) pres++; else closes++;
			sdram_ctrl_pkg::CMD_REFRESH: rfrs++;
			sdram_ctrl_pkg::CMD_MODE_SET: modes++;
			default: ;
		endcase
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_IN);
		#2;
	endtask : tick
	function automatic logic [23:0] ad(input int b, input int r, input int cl);
		return {1'b0, 2'(b), 11'(r), 8'(cl), 2'b00};
	endfunction : ad
	// one request; dop is the number of row opens it should cost
	task automatic step(input logic w, input logic [1:0] sp, input logic [23:0] a,
		input logic [3:0] be, input logic [31:0] wd, input int dop);
		int n, o;
		n = 0;
		while (REQ_READY_OUT !== 1'b1 && n < 100) begin tick(1); n++; end
		o = opens;
		{REQ_WRITE_IN, REQ_SPACE_IN, REQ_ADDR_IN, REQ_BE_IN, REQ_WDATA_IN} = {w, sp, a, be, wd};
		REQ_VALID_IN = 1'b1;
		tick(1);
		REQ_VALID_IN = 1'b0;
		n = 0;
		while (DONE_OUT !== 1'b1 && n < 400) begin tick(1); n++; end
		chk({31'h0, DONE_OUT}, 32'h1);
		rd = RDATA_OUT;
		chk(opens - o, dop);
	endtask : step
	task automatic init_run();
		int n, m, r, p;
		{m, r, p, n} = {modes, rfrs, pres, 32'h0};
		INIT_WRITE_IN = 1'b1;
		tick(1);
		INIT_WRITE_IN = 1'b0;
		while ((modes == m || INIT_DONE_OUT !== 1'b1) && n < 100) begin tick(1); n++; end
		chk(pres - p, 1);
		chk(rfrs - r, 8);
		chk(modes - m, 1);
		chk({31'h0, INIT_DONE_OUT}, 32'h1);
	endtask : init_run
	initial begin
		a0 = ad(0, 5, 3);
		tick(4);
		chk({CS_N_OUT, BYTE_ENABLE_N_OUT, DQ_OE_N_OUT, INIT_DONE_OUT, REQ_READY_OUT}, 32'h3FFC);
		NRST_IN = 1'b1;
		tick(20);
		chk(pres, 0);
		HOLD_REQ_N_IN = 1'b1;
		tick(10);
		chk(pres, 1);
		chk(rfrs, 0);
		init_run();
		step(1, 0, a0, 4'hF, D1, 1);
		chk(row_seen[12:0], a0[22:10]);
		chk({col_seen[12:11], col_seen[10:0]}, {a0[22:21], 3'h0, a0[9:2]});
		step(0, 0, a0, 4'hF, 0, 0);
		chk(rd, D1);
		step(1, 0, a0, 4'h3, D2, 0);
		step(0, 0, a0, 4'hF, 0, 0);
		chk(rd, {D1[31:16], D2[15:0]});
		c = closes;
		step(0, 0, ad(0, 6, 3), 4'hF, 0, 1);
		chk(closes - c, 1);
		for (int b = 1; b < 4; b++)
			step(1, 0, ad(b, 5, b), 4'hF, b, 1);
		c = closes;
		step(1, 2, a0, 4'hF, D2, 1);
		chk(closes - c, 1);
		step(0, 0, ad(1, 5, 1), 4'hF, 0, 0);
		chk(rd, 1);
		step(0, 0, ad(0, 6, 3), 4'hF, 0, 1);
		step(0, 2, a0, 4'hF, 0, 0);
		chk(rd, D2);
		step(0, 0, ad(1, 5, 1) | 24'h800000, 4'hF, 0, 1);
		CAS_LAT3_IN = 1'b1;
		init_run();
		step(1, 0, a0, 4'hF, D2, 1);
		step(0, 0, a0, 4'hF, 0, 0);
		chk(rd, D2);
		SELF_REFRESH_IN = 1'b1;
		tick(3);
		chk({31'h0, CLK_ENABLE_OUT}, 32'h0);
		SELF_REFRESH_IN = 1'b0;
		tick(3);
		chk({31'h0, CLK_ENABLE_OUT}, 32'h1);
		give_verdict();
	end
endmodule : sdram_page_init_addr_ctrl_bench
`default_nettype wire
